// ==== logic/xio_port.sv ====
module xio_port
  import xio_pkg::*;
(
  // clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // main general port
  input wire logic [7:0] main_in,
  output logic [7:0] main_out,
  // extended points 17..48
  input wire logic [31:0] ext_in,
  output logic [31:0] ext_out,
  output logic [31:0] ext_oe
);
  xio_state_e state;
  logic pend;
  logic wr_q;
  logic [7:0] addr_q;
  logic [3:0] dir;
  logic [2:0] bsel;
  logic [5:0] psel;
  logic [7:0] main_in_s;
  logic [31:0] ext_in_s;
  logic [43:0] nv_data;
  logic nv_valid;
  logic accept;
  logic wr_en;
  logic rd_en;
  logic [31:0] ext_mask;
  logic [31:0] ext_view;
  logic [5:0] bit_pt;
  logic [1:0] bit_op;
  logic bit_lvl;
  logic bit_hit;
  logic main_hit;
  logic ext_hit;
  logic [5:0] pt_main_ofs;
  logic [5:0] pt_ext_ofs;
  logic save_go;
  logic [7:0] next_main_out;
  logic [31:0] next_ext_out;
  logic [31:0] next_hrdata;
  logic [7:0] blk_val;
  logic pt_val;
  logic [5:0] psel_main_ofs;
  logic [5:0] psel_ext_ofs;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and saved state

  xio_sync #(.W(8)) u_sync_main (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(main_in),
    .q(main_in_s)
  );

  xio_sync #(.W(32)) u_sync_ext (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(ext_in),
    .q(ext_in_s)
  );

  xio_nvstore #(.W(44)) u_nv (
    .hclk(hclk),
    .por_n(por_n),
    .we(save_go),
    .wdata({dir, main_out, ext_out}),
    .rdata(nv_data),
    .valid(nv_valid)
  );

  ////////////////////////////////////////////////////////////////////
  // bus slave: one wait state on every transfer

  assign accept = hsel && htrans[1] && hready;
  assign wr_en = pend && wr_q && (state == XIO_RUN);
  assign rd_en = pend && !wr_q;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else if (accept)
    begin
      pend <= 1'b1;
      wr_q <= hwrite;
      addr_q <= {haddr[7:2], 2'h0};
    end
    else
    begin
      pend <= 1'b0;
    end
  end

  // ready low in first data cycle, high in second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= !accept;
      hresp <= 1'b0; // always okay
    end
  end

  // read data register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      hrdata <= next_hrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // start-up: restore saved setting once after reset

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= XIO_RESTORE;
    end
    else
    begin
      state <= XIO_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // direction word

  // per block enable, bit 0 is block 2
  assign ext_mask = {{8{dir[3]}}, {8{dir[2]}}, {8{dir[1]}}, {8{dir[0]}}};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dir <= XIO_DIR_RST;
    end
    else if (state == XIO_RESTORE)
    begin
      dir <= nv_valid ? nv_data[43:40] : XIO_DIR_RST;
    end
    else if (wr_en && addr_q == XIO_OFS_DIR)
    begin
      dir <= hwdata[3:0];
    end
  end

  // pin drivers follow direction one cycle later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_oe <= 32'h0000_0000;
    end
    else
    begin
      ext_oe <= ext_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // single bit commands

  assign bit_pt = hwdata[XIO_BIT_PT_LSB +: 6];
  assign bit_op = hwdata[XIO_BIT_OP_LSB +: 2];
  assign bit_hit = wr_en && (addr_q == XIO_OFS_BIT) && (bit_op != 2'h0);
  assign pt_main_ofs = bit_pt - XIO_MAIN_FIRST;
  assign pt_ext_ofs = bit_pt - XIO_EXT_FIRST;
  assign main_hit = bit_hit && bit_pt >= XIO_MAIN_FIRST && bit_pt <= XIO_MAIN_LAST;
  assign ext_hit = bit_hit && bit_pt >= XIO_EXT_FIRST && bit_pt <= XIO_EXT_LAST;

  // level from command: set, clear or supplied value
  always_comb
  begin
    unique case (bit_op)
      XIO_OP_SET: bit_lvl = 1'b1;
      XIO_OP_CLR: bit_lvl = 1'b0;
      XIO_OP_COND: bit_lvl = hwdata[XIO_BIT_VAL];
      default: bit_lvl = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // output levels

  // main port next value
  always_comb
  begin
    next_main_out = main_out;
    if (wr_en && addr_q == XIO_OFS_MAIN)
    begin
      next_main_out = hwdata[7:0];
    end
    if (main_hit)
    begin
      next_main_out[pt_main_ofs[2:0]] = bit_lvl;
    end
  end

  // extended next value, input points untouched
  always_comb
  begin
    next_ext_out = ext_out;
    if (wr_en && addr_q == XIO_OFS_GRPA)
    begin
      next_ext_out[15:0] = (hwdata[15:0] & ext_mask[15:0])
        | (ext_out[15:0] & ~ext_mask[15:0]);
    end
    if (wr_en && addr_q == XIO_OFS_GRPB)
    begin
      next_ext_out[31:16] = (hwdata[15:0] & ext_mask[31:16])
        | (ext_out[31:16] & ~ext_mask[31:16]);
    end
    if (ext_hit && ext_mask[pt_ext_ofs[4:0]])
    begin
      next_ext_out[pt_ext_ofs[4:0]] = bit_lvl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      main_out <= XIO_MAIN_RST;
      ext_out <= XIO_EXT_RST;
    end
    else if (state == XIO_RESTORE)
    begin
      main_out <= nv_valid ? nv_data[39:32] : XIO_MAIN_RST;
      ext_out <= nv_valid ? nv_data[31:0] : XIO_EXT_RST;
    end
    else
    begin
      main_out <= next_main_out;
      ext_out <= next_ext_out;
    end
  end

  // save command
  assign save_go = wr_en && (addr_q == XIO_OFS_SAVE) && hwdata[XIO_SAVE_GO];

  ////////////////////////////////////////////////////////////////////
  // read side

  // select registers for block and point reads
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bsel <= XIO_BSEL_RST;
      psel <= XIO_PSEL_RST;
    end
    else
    begin
      if (wr_en && addr_q == XIO_OFS_BSEL)
      begin
        bsel <= hwdata[2:0];
      end
      if (wr_en && addr_q == XIO_OFS_PSEL)
      begin
        psel <= hwdata[5:0];
      end
    end
  end

  // inputs read their pins, outputs their driven level
  assign ext_view = (ext_in_s & ~ext_mask) | (ext_out & ext_mask);

  // block value, lowest point in lsb
  always_comb
  begin
    unique case (bsel)
      XIO_BLK_MAIN: blk_val = main_in_s;
      3'h2: blk_val = ext_view[7:0];
      3'h3: blk_val = ext_view[15:8];
      3'h4: blk_val = ext_view[23:16];
      3'h5: blk_val = ext_view[31:24];
      default: blk_val = 8'h00;
    endcase
  end

  // single point level
  assign psel_main_ofs = psel - XIO_MAIN_FIRST;
  assign psel_ext_ofs = psel - XIO_EXT_FIRST;

  always_comb
  begin
    pt_val = 1'b0;
    if (psel >= XIO_MAIN_FIRST && psel <= XIO_MAIN_LAST)
    begin
      pt_val = main_in_s[psel_main_ofs[2:0]];
    end
    else if (psel >= XIO_EXT_FIRST && psel <= XIO_EXT_LAST)
    begin
      pt_val = ext_view[psel_ext_ofs[4:0]];
    end
  end

  // register read mux, unmapped reads zero
  always_comb
  begin
    next_hrdata = 32'h0000_0000;
    unique case (addr_q)
      XIO_OFS_DIR: next_hrdata[3:0] = dir;
      XIO_OFS_MAIN: next_hrdata[7:0] = main_out;
      XIO_OFS_GRPA: next_hrdata[15:0] = ext_out[15:0];
      XIO_OFS_GRPB: next_hrdata[15:0] = ext_out[31:16];
      XIO_OFS_BSEL: next_hrdata[2:0] = bsel;
      XIO_OFS_BDATA: next_hrdata[7:0] = blk_val;
      XIO_OFS_PSEL: next_hrdata[5:0] = psel;
      XIO_OFS_PLVL: next_hrdata[0] = pt_val;
      XIO_OFS_SAVE: next_hrdata[0] = nv_valid;
      default: next_hrdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_wr(logic [7:0] ofs);
    wr_en && addr_q == ofs;
  endsequence

  sequence s_wait_ready;
    !hreadyout ##1 hreadyout;
  endsequence

  a_bus_wait: assert property (accept |=> s_wait_ready)
    else $error("bus answer not after one wait state");

  a_dir_write: assert property (s_wr(XIO_OFS_DIR) |=> dir == $past(hwdata[3:0]))
    else $error("direction write not stored");

  a_oe_follow: assert property ($changed(dir)
    |=> ext_oe == {{8{$past(dir[3])}}, {8{$past(dir[2])}}, {8{$past(dir[1])}}, {8{$past(dir[0])}}})
    else $error("drivers did not follow direction");

  a_inputs_kept: assert property ($past(state) == XIO_RUN
    |-> ((ext_out ^ $past(ext_out)) & ~$past(ext_mask)) == 32'h0000_0000)
    else $error("input point level changed");

  a_grp_write: assert property (s_wr(XIO_OFS_GRPB) |=>
    ext_out[31:16] == (($past(hwdata[15:0]) & $past(ext_mask[31:16]))
      | ($past(ext_out[31:16]) & ~$past(ext_mask[31:16])))
    && ext_out[15:0] == $past(ext_out[15:0]))
    else $error("group write wrong");

  a_main_write: assert property (s_wr(XIO_OFS_MAIN) && !main_hit
    |=> main_out == $past(hwdata[7:0]))
    else $error("main port write wrong");

  a_bit_main: assert property (main_hit
    |=> main_out[$past(pt_main_ofs[2:0])] == $past(bit_lvl))
    else $error("main bit command wrong");

  a_dir_default: assert property (state == XIO_RESTORE && !nv_valid |=> dir == 4'h0)
    else $error("direction not zero at start");

  a_save_store: assert property (save_go |=> nv_valid && nv_data[43:40] == $past(dir))
    else $error("save did not store direction");

  a_blk_read: assert property (rd_en && addr_q == XIO_OFS_BDATA && bsel == 3'h2 && !dir[0]
    |=> hreadyout && hrdata[7:0] == $past(ext_in_s[7:0]))
    else $error("block read wrong");
endmodule : xio_port

// ==== logic/xio_pkg.sv ====
// Functional notes
// - 32 extended points; direction chosen only per block of 8 adjacent points.
// - extended points 17..48 form blocks 2..5, eight points each.
// - direction bit 1 makes its block outputs, 0 makes it inputs.
// - direction bit 0 selects block 2, bit 3 selects block 5.
// - with no saved setting the direction word starts at zero.
// - save command stores direction and output levels for the next start.
// - single output points 1..8 and 17..48 can be set or cleared.
// - conditional bit write drives the point from a supplied true/false value.
// - group writes: 8 bits for points 1..8, 16 bits per extended half.
// - group write bits aimed at input points are dropped.
// - lsb of a group value maps to its lowest numbered point.
// - a written group has its output points overwritten, its input points kept; unwritten groups keep levels.
// - an input block reads back with its lowest point in the lsb.
// - any single point level can be read; point 17 is block 2 lsb.
// - main port bit 0 drives output 1, bit 7 drives output 8.
package xio_pkg;
  // register byte offsets
  localparam logic [7:0] XIO_OFS_DIR = 8'h00;
  localparam logic [7:0] XIO_OFS_MAIN = 8'h04;
  localparam logic [7:0] XIO_OFS_GRPA = 8'h08;
  localparam logic [7:0] XIO_OFS_GRPB = 8'h0c;
  localparam logic [7:0] XIO_OFS_BIT = 8'h10;
  localparam logic [7:0] XIO_OFS_BSEL = 8'h14;
  localparam logic [7:0] XIO_OFS_BDATA = 8'h18;
  localparam logic [7:0] XIO_OFS_PSEL = 8'h1c;
  localparam logic [7:0] XIO_OFS_PLVL = 8'h20;
  localparam logic [7:0] XIO_OFS_SAVE = 8'h24;
  // values after reset
  localparam logic [3:0] XIO_DIR_RST = 4'h0;
  localparam logic [7:0] XIO_MAIN_RST = 8'h00;
  localparam logic [31:0] XIO_EXT_RST = 32'h0000_0000;
  localparam logic [2:0] XIO_BSEL_RST = 3'h0;
  localparam logic [5:0] XIO_PSEL_RST = 6'h00;
  // bit command field positions
  localparam int XIO_BIT_PT_LSB = 0;
  localparam int XIO_BIT_OP_LSB = 8;
  localparam int XIO_BIT_VAL = 12;
  localparam int XIO_SAVE_GO = 0;
  // bit command codes
  localparam logic [1:0] XIO_OP_SET = 2'h1;
  localparam logic [1:0] XIO_OP_CLR = 2'h2;
  localparam logic [1:0] XIO_OP_COND = 2'h3;
  // point numbering
  localparam logic [5:0] XIO_MAIN_FIRST = 6'h01;
  localparam logic [5:0] XIO_MAIN_LAST = 6'h08;
  localparam logic [5:0] XIO_EXT_FIRST = 6'h11;
  localparam logic [5:0] XIO_EXT_LAST = 6'h30;
  // block numbers for block reads
  localparam logic [2:0] XIO_BLK_MAIN = 3'h0;
  localparam logic [2:0] XIO_BLK_FIRST = 3'h2;
  localparam logic [2:0] XIO_BLK_LAST = 3'h5;
  // start-up sequencing
  typedef enum logic [0:0] {
    XIO_RESTORE = 1'b0,
    XIO_RUN = 1'b1
  } xio_state_e;
endpackage : xio_pkg

// ==== logic/xio_sync.sv ====
module xio_sync
  import xio_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // level in, level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // two flop synchroniser, meta read only by q
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : xio_sync

// ==== logic/xio_nvstore.sv ====
module xio_nvstore
  import xio_pkg::*;
#(
  parameter int W = 44
) (
  // clock and power-on clear
  input wire logic hclk,
  input wire logic por_n,
  // store port
  input wire logic we,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rdata,
  output logic valid
);
  // survives hresetn, cleared only at power-on
  always_ff @(posedge hclk or negedge por_n)
  begin
    if (!por_n)
    begin
      rdata <= '0;
      valid <= 1'b0;
    end
    else if (we)
    begin
      rdata <= wdata;
      valid <= 1'b1;
    end
  end
endmodule : xio_nvstore

// ==== bench/xio_field.sv ====
module xio_field
(
  // pins seen from the field side
  input wire logic [31:0] ext_out,
  input wire logic [31:0] ext_oe,
  input wire logic [31:0] sw_level,
  output logic [31:0] ext_in
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////////////////////
  // driven points loop back, undriven points show the switch level
  assign ext_in = (ext_out & ext_oe) | (sw_level & ~ext_oe);
endmodule : xio_field

// ==== bench/extended_io_port_bench.sv ====
module extended_io_port_bench
  import xio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic por_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] main_in = 8'h00;
  logic [7:0] main_out;
  logic [31:0] ext_in;
  logic [31:0] ext_out;
  logic [31:0] ext_oe;
  logic [31:0] sw_level = 32'h0;
  logic [31:0] rd;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////////////////////
  // clock and timeout
  initial
  begin
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  xio_port u_dut (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .main_in(main_in),
    .main_out(main_out), .ext_in(ext_in), .ext_out(ext_out), .ext_oe(ext_oe)
  );
  xio_field u_field (.ext_out(ext_out), .ext_oe(ext_oe), .sw_level(sw_level), .ext_in(ext_in));
  ////////////////////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one single ahb transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : wait_cyc
  function automatic logic [31:0] bitcmd(input logic [5:0] pt, input logic [1:0] op,
                                         input logic v);
    return {19'h0, v, 2'h0, op, 2'h0, pt};
  endfunction : bitcmd
  ////////////////////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    bus(1'b0, XIO_OFS_DIR, 32'h0);
    check("dir", rd, 32'h0);
    check("oe", ext_oe, 32'h0);
    bus(1'b0, XIO_OFS_SAVE, 32'h0);
    check("saved", rd, 32'h0);
    check("resp", {31'h0, hresp}, 32'h0);
  endtask : t_reset
  task automatic t_direction();
    bus(1'b1, XIO_OFS_DIR, 32'hc);
    wait_cyc(2);
    check("oe c", ext_oe, 32'hffff_0000);
    bus(1'b1, XIO_OFS_DIR, 32'h4);
    wait_cyc(2);
    check("oe 4", ext_oe, 32'h00ff_0000);
  endtask : t_direction
  task automatic t_group();
    bus(1'b1, XIO_OFS_GRPA, 32'hffff);
    check("grpa pins", ext_out, 32'h0);
    bus(1'b0, XIO_OFS_GRPA, 32'h0);
    check("grpa read", rd, 32'h0);
    bus(1'b1, XIO_OFS_GRPB, 32'hffff);
    check("grpb mask", ext_out, 32'h00ff_0000);
    bus(1'b1, XIO_OFS_GRPB, 32'h0007);
    check("grpb lsb", ext_out, 32'h0007_0000);
    bus(1'b1, XIO_OFS_MAIN, 32'h6);
    check("main 6", main_out, 8'h06);
    bus(1'b1, XIO_OFS_MAIN, 32'hff);
    check("main ff", main_out, 8'hff);
    bus(1'b1, XIO_OFS_MAIN, 32'h6);
    check("grpb kept", ext_out, 32'h0007_0000);
  endtask : t_group
  task automatic t_bits();
    bus(1'b1, XIO_OFS_BIT, bitcmd(6'd17, XIO_OP_SET, 1'b0));
    bus(1'b1, XIO_OFS_BIT, bitcmd(6'd33, XIO_OP_CLR, 1'b0));
    bus(1'b1, XIO_OFS_BIT, bitcmd(6'd34, XIO_OP_COND, 1'b0));
    bus(1'b1, XIO_OFS_BIT, bitcmd(6'd36, XIO_OP_COND, 1'b1));
    bus(1'b1, XIO_OFS_BIT, bitcmd(6'd40, XIO_OP_SET, 1'b0));
    check("ext bits", ext_out, 32'h008c_0000);
    bus(1'b1, XIO_OFS_BIT, bitcmd(6'd8, XIO_OP_SET, 1'b0));
    bus(1'b1, XIO_OFS_BIT, bitcmd(6'd2, XIO_OP_CLR, 1'b0));
    check("main bits", main_out, 8'h84);
  endtask : t_bits
  task automatic t_inputs();
    logic [7:0] exp_blk [5] = '{8'h96, 8'h3c, 8'h5a, 8'h8c, 8'ha5};
    logic [2:0] blk [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
    logic [5:0] pts [5] = '{6'd1, 6'd2, 6'd17, 6'd19, 6'd48};
    logic exp_pt [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    @(posedge hclk);
    main_in <= 8'h96;
    sw_level <= 32'ha5c3_5a3c;
    wait_cyc(4);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, XIO_OFS_BSEL, {29'h0, blk[i]});
      bus(1'b0, XIO_OFS_BDATA, 32'h0);
      check("block", rd, {24'h0, exp_blk[i]});
      bus(1'b1, XIO_OFS_PSEL, {26'h0, pts[i]});
      bus(1'b0, XIO_OFS_PLVL, 32'h0);
      check("point", rd, {31'h0, exp_pt[i]});
    end
  endtask : t_inputs
  task automatic t_save();
    bus(1'b1, XIO_OFS_SAVE, 32'h1);
    bus(1'b0, XIO_OFS_SAVE, 32'h0);
    check("saved", rd, 32'h1);
    bus(1'b1, XIO_OFS_DIR, 32'h0);
    bus(1'b1, XIO_OFS_MAIN, 32'h0);
    wait_cyc(2);
    check("oe off", ext_oe, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    wait_cyc(3);
    hresetn <= 1'b1;
    wait_cyc(3);
    check("main back", main_out, 8'h84);
    check("ext back", ext_out, 32'h008c_0000);
    check("oe back", ext_oe, 32'h00ff_0000);
    bus(1'b0, XIO_OFS_DIR, 32'h0);
    check("dir back", rd, 32'h4);
    bus(1'b1, 8'h30, 32'hf);
    bus(1'b0, 8'h30, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b0, XIO_OFS_DIR, 32'h0);
    check("dir kept", rd, 32'h4);
  endtask : t_save
  ////////////////////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    wait_cyc(1);
    por_n <= 1'b1;
    wait_cyc(5);
    hresetn <= 1'b1;
    t_reset();
    t_direction();
    t_group();
    t_bits();
    t_inputs();
    t_save();
    finish_test();
  end
endmodule : extended_io_port_bench
